// ===== hdl/nor_host_pkg.sv
package nor_host_pkg;

	// ************************************************************
	// timing, all at the 20 ns clock
	// ************************************************************
	localparam int CLK_NS = 20;
	localparam int T_ACC_NS = 70;
	localparam int T_AS_NS = 20;
	localparam int T_WP_NS = 40;
	localparam int T_WH_NS = 20;
	localparam int T_BUSY_NS = 100;
	localparam int T_RP_NS = 500;
	localparam int T_RH_NS = 200;
	localparam int SYNC_CYC = 3;
	localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RD_CYC = 8'(ACC_CYC + SYNC_CYC);
	localparam logic [7:0] AS_CYC = 8'((T_AS_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] WH_CYC = 8'((T_WH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] BUSY_CYC = 8'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] RH_CYC = 8'((T_RH_NS + CLK_NS - 1) / CLK_NS);

	// ************************************************************
	// own register map
	// ************************************************************
	localparam logic [7:0] OFF_CMD = 8'h00;
	localparam logic [7:0] OFF_ADDR = 8'h04;
	localparam logic [7:0] OFF_WDATA = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_RDATA = 8'h10;
	localparam logic [7:0] OFF_PINCTRL = 8'h14;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_ERR = 2;
	localparam int ST_READY = 3;
	localparam int PC_WP_HIGH = 0;
	localparam int PC_WP_VID = 1;
	localparam int PC_RESET_VID = 2;

	// ************************************************************
	// flash command codes and addresses
	// ************************************************************
	localparam logic [7:0] CMD_UNLOCK1 = 8'hAA;
	localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
	localparam logic [7:0] CMD_PROGRAM = 8'hA0;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_BLOCK_ERASE = 8'h30;
	localparam logic [7:0] CMD_SUSPEND = 8'hB0;
	localparam logic [7:0] CMD_RESUME = 8'h30;
	localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
	localparam logic [7:0] CMD_BYPASS = 8'h20;
	localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
	localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [22:0] ADDR_UNLOCK1 = 23'h000555;
	localparam logic [22:0] ADDR_UNLOCK2 = 23'h0002AA;
	localparam logic [19:0] BANK_LOW_555 = 20'h00555;
	localparam logic [11:0] PROT_LOW = 12'h002;
	localparam logic [11:0] UNPROT_LOW = 12'h042;

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [3:0] {
		OP_READ, OP_RESET, OP_PROGRAM, OP_CHIP_ERASE, OP_BLOCK_ERASE, OP_SUSPEND, OP_RESUME,
		OP_AUTOSELECT, OP_BYPASS_ENTER, OP_BYPASS_PROGRAM, OP_BYPASS_BLOCK_ERASE,
		OP_BYPASS_CHIP_ERASE, OP_BYPASS_EXIT, OP_PROTECT, OP_UNPROTECT, OP_HW_RESET
	} op_type;

	typedef enum logic [2:0] {
		AK_555, AK_2AA, AK_USER, AK_BANK555, AK_BANK, AK_ANY, AK_PROT, AK_UNPROT
	} addr_kind_type;

	typedef enum logic [3:0] {
		PH_IDLE, PH_WR_SETUP, PH_WR_LOW, PH_WR_HOLD, PH_RD_ACCESS, PH_BUSY_SETTLE,
		PH_WAIT_READY, PH_RST_PULSE, PH_RST_RECOVER
	} phase_type;

	typedef struct packed {
		logic last;
		logic wait_ready;
		addr_kind_type akind;
		logic use_wdata;
		logic [7:0] code;
	} step_type;

	typedef struct packed {
		logic [22:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic reset_n;
		logic reset_vid;
		logic wp_accel;
		logic wp_accel_vid;
	} flash_pins_type;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_type;

	localparam step_type STEP_NONE = '{1'b1, 1'b0, AK_ANY, 1'b0, 8'h00};
	localparam flash_pins_type PINS_IDLE = '{23'h000000, 16'h0000, 1'b0, 1'b1, 1'b1, 1'b1,
		1'b1, 1'b0, 1'b0, 1'b0};

endpackage

// ===== hdl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 17
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);
	import nor_host_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} sync_type;

	sync_type sync_ff;
	sync_type nxt_sync;
	logic [WIDTH-1:0] nxt_q;

	// ************************************************************
	// per bit: accept a change only when stages two and three agree
	// ************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			assign nxt_q[gi] = (sync_ff.s2[gi] == sync_ff.s3[gi]) ? sync_ff.s3[gi] : sync_ff.q[gi];
		end
	endgenerate

	always_comb begin
		nxt_sync.s1 = i_pin;
		nxt_sync.s2 = sync_ff.s1;
		nxt_sync.s3 = sync_ff.s2;
		nxt_sync.q = nxt_q;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			sync_ff <= '0;
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	assign o_level = sync_ff.q;
endmodule // pin_sync

// ===== hdl/nor_flash_host.sv
// Function
// - every command except read and hardware reset issued as bus writes
// - program is four writes, unlock first
// - erase is six writes, chip or block
// - identify: unlock then 90 at bank
// - bypass block erase is 80 then 30
// - bypass enter 20, chip erase, exit 90/00
// - protect: write with reset at high voltage
// - unprotect: same with address bit 6 high
// - block address on upper address bits
// - reset code F0 leaves identify mode
`timescale 1ns/1ps
module nor_flash_host (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire nor_host_pkg::apb_req_type i_apb,
	output nor_host_pkg::apb_rsp_type o_apb,
	output nor_host_pkg::flash_pins_type o_flash,
	input wire logic [15:0] i_dq_in,
	input wire logic i_ready_busy_n
);
	import nor_host_pkg::*;

	typedef struct packed {
		phase_type phase;
		logic [7:0] cnt;
		logic [2:0] idx;
		op_type op;
		step_type step;
		logic [22:0] addr_reg;
		logic [15:0] wdata_reg;
		logic [15:0] rdata;
		logic [2:0] pin_ctrl;
		logic done;
		logic err;
		logic [31:0] prdata;
		logic pslverr;
		flash_pins_type pins;
	} state_type;

	localparam state_type ST_RESET = '{phase: PH_IDLE, op: OP_READ, step: STEP_NONE,
		pins: PINS_IDLE, default: '0};

	state_type st_ff;
	state_type nxt_st;
	logic [16:0] synced;
	logic ready_sync;
	logic [15:0] dq_sync;

	// ************************************************************
	// pin inputs
	// ************************************************************
	pin_sync #(
		.WIDTH(17)
	) u_sync (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_pin({i_ready_busy_n, i_dq_in}),
		.o_level(synced)
	);
	assign ready_sync = synced[16];
	assign dq_sync = synced[15:0];

	// ************************************************************
	// command sequences
	// ************************************************************
	function automatic step_type seq_step(input op_type op, input logic [2:0] idx);
		step_type s;
		logic unl;
		s = STEP_NONE;
		unl = (op == OP_PROGRAM) || (op == OP_CHIP_ERASE) || (op == OP_BLOCK_ERASE) ||
			(op == OP_AUTOSELECT) || (op == OP_BYPASS_ENTER);
		if (unl && (idx == 3'd0)) begin
			s = '{1'b0, 1'b0, AK_555, 1'b0, CMD_UNLOCK1};
		end else if (unl && (idx == 3'd1)) begin
			s = '{1'b0, 1'b0, AK_2AA, 1'b0, CMD_UNLOCK2};
		end else begin
			case (op)
				OP_RESET: s = '{1'b1, 1'b0, AK_ANY, 1'b0, CMD_RESET};
				OP_PROGRAM: s = (idx == 3'd2) ?
					step_type'{1'b0, 1'b0, AK_555, 1'b0, CMD_PROGRAM} :
					step_type'{1'b1, 1'b1, AK_USER, 1'b1, 8'h00};
				OP_CHIP_ERASE, OP_BLOCK_ERASE: begin
					case (idx)
						3'd2: s = '{1'b0, 1'b0, AK_555, 1'b0, CMD_ERASE_SETUP};
						3'd3: s = '{1'b0, 1'b0, AK_555, 1'b0, CMD_UNLOCK1};
						3'd4: s = '{1'b0, 1'b0, AK_2AA, 1'b0, CMD_UNLOCK2};
						default: s = (op == OP_CHIP_ERASE) ?
							step_type'{1'b1, 1'b1, AK_555, 1'b0, CMD_CHIP_ERASE} :
							step_type'{1'b1, 1'b1, AK_USER, 1'b0, CMD_BLOCK_ERASE};
					endcase
				end
				// suspend halts the internal work, so wait for ready again
				OP_SUSPEND: s = '{1'b1, 1'b1, AK_BANK, 1'b0, CMD_SUSPEND};
				OP_RESUME: s = '{1'b1, 1'b0, AK_BANK, 1'b0, CMD_RESUME};
				OP_AUTOSELECT: s = '{1'b1, 1'b0, AK_BANK555, 1'b0, CMD_AUTOSELECT};
				OP_BYPASS_ENTER: s = '{1'b1, 1'b0, AK_555, 1'b0, CMD_BYPASS};
				OP_BYPASS_PROGRAM: s = (idx == 3'd0) ?
					step_type'{1'b0, 1'b0, AK_ANY, 1'b0, CMD_PROGRAM} :
					step_type'{1'b1, 1'b1, AK_USER, 1'b1, 8'h00};
				OP_BYPASS_BLOCK_ERASE: s = (idx == 3'd0) ?
					step_type'{1'b0, 1'b0, AK_ANY, 1'b0, CMD_ERASE_SETUP} :
					step_type'{1'b1, 1'b1, AK_USER, 1'b0, CMD_BLOCK_ERASE};
				OP_BYPASS_CHIP_ERASE: s = (idx == 3'd0) ?
					step_type'{1'b0, 1'b0, AK_ANY, 1'b0, CMD_ERASE_SETUP} :
					step_type'{1'b1, 1'b1, AK_ANY, 1'b0, CMD_CHIP_ERASE};
				OP_BYPASS_EXIT: s = (idx == 3'd0) ?
					step_type'{1'b0, 1'b0, AK_ANY, 1'b0, CMD_BYPASS_EXIT1} :
					step_type'{1'b1, 1'b0, AK_ANY, 1'b0, CMD_BYPASS_EXIT2};
				OP_PROTECT: s = '{1'b1, 1'b1, AK_PROT, 1'b0, 8'h00};
				OP_UNPROTECT: s = '{1'b1, 1'b1, AK_UNPROT, 1'b0, 8'h00};
				default: s = STEP_NONE;
			endcase
		end
		return s;
	endfunction

	function automatic logic [22:0] step_addr(input addr_kind_type k, input logic [22:0] ua);
		logic [22:0] a;
		a = 23'h000000;
		case (k)
			AK_555: a = ADDR_UNLOCK1;
			AK_2AA: a = ADDR_UNLOCK2;
			AK_USER: a = ua;
			AK_BANK555: a = {ua[22:20], BANK_LOW_555};
			AK_BANK: a = {ua[22:20], 20'h00000};
			AK_PROT: a = {ua[22:12], PROT_LOW};
			AK_UNPROT: a = {ua[22:12], UNPROT_LOW};
			default: a = 23'h000000;
		endcase
		return a;
	endfunction

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		logic setup;
		logic access;
		logic busy;
		logic set_done;
		logic set_err;
		logic [1:0] clr;
		logic begin_write;
		step_type bw;
		setup = i_apb.psel && !i_apb.penable;
		access = i_apb.psel && i_apb.penable;
		busy = (st_ff.phase != PH_IDLE);
		set_done = 1'b0;
		set_err = access && i_apb.pwrite && st_ff.pslverr && (i_apb.paddr == OFF_CMD);
		clr = 2'b00;
		begin_write = 1'b0;
		bw = STEP_NONE;
		nxt_st = st_ff;

		// register bus: read data and refusal fixed in the setup cycle
		if (setup) begin
			nxt_st.pslverr = 1'b0;
			case (i_apb.paddr)
				OFF_CMD: begin
					nxt_st.prdata = {28'h0000000, st_ff.op};
					nxt_st.pslverr = i_apb.pwrite && busy;
				end
				OFF_ADDR: nxt_st.prdata = {9'h000, st_ff.addr_reg};
				OFF_WDATA: nxt_st.prdata = {16'h0000, st_ff.wdata_reg};
				OFF_STATUS: nxt_st.prdata = {28'h0000000, ready_sync, st_ff.err, st_ff.done, busy};
				OFF_RDATA: nxt_st.prdata = {16'h0000, st_ff.rdata};
				OFF_PINCTRL: nxt_st.prdata = {29'h00000000, st_ff.pin_ctrl};
				default: begin
					nxt_st.prdata = 32'h00000000;
					nxt_st.pslverr = 1'b1;
				end
			endcase
		end
		if (access && i_apb.pwrite && !st_ff.pslverr) begin
			case (i_apb.paddr)
				OFF_ADDR: nxt_st.addr_reg = i_apb.pwdata[22:0];
				OFF_WDATA: nxt_st.wdata_reg = i_apb.pwdata[15:0];
				OFF_STATUS: clr = i_apb.pwdata[ST_ERR:ST_DONE];
				OFF_PINCTRL: nxt_st.pin_ctrl = i_apb.pwdata[2:0];
				OFF_CMD: begin
					nxt_st.op = op_type'(i_apb.pwdata[3:0]);
					nxt_st.idx = 3'd0;
					if (op_type'(i_apb.pwdata[3:0]) == OP_READ) begin
						nxt_st.phase = PH_RD_ACCESS;
						nxt_st.cnt = RD_CYC;
						nxt_st.pins.addr = st_ff.addr_reg;
						nxt_st.pins.ce_n = 1'b0;
						nxt_st.pins.oe_n = 1'b0;
					end else if (op_type'(i_apb.pwdata[3:0]) == OP_HW_RESET) begin
						nxt_st.phase = PH_RST_PULSE;
						nxt_st.cnt = RP_CYC;
						nxt_st.pins.reset_n = 1'b0;
					end else begin
						begin_write = 1'b1;
						bw = seq_step(op_type'(i_apb.pwdata[3:0]), 3'd0);
					end
				end
				default: begin
				end
			endcase
		end
		// flash bus cycles
		unique case (st_ff.phase)
			PH_IDLE: begin
			end
			PH_WR_SETUP: begin
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.pins.we_n = 1'b0;
					nxt_st.cnt = WP_CYC;
					nxt_st.phase = PH_WR_LOW;
				end
			end
			PH_WR_LOW: begin
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.pins.we_n = 1'b1;
					nxt_st.cnt = WH_CYC;
					nxt_st.phase = PH_WR_HOLD;
				end
			end
			PH_WR_HOLD: begin
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.pins.ce_n = 1'b1;
					nxt_st.pins.dq_oe = 1'b0;
					if (!st_ff.step.last) begin
						nxt_st.idx = st_ff.idx + 3'd1;
						begin_write = 1'b1;
						bw = seq_step(st_ff.op, st_ff.idx + 3'd1);
					end else if (st_ff.step.wait_ready) begin
						nxt_st.cnt = BUSY_CYC;
						nxt_st.phase = PH_BUSY_SETTLE;
					end else begin
						nxt_st.phase = PH_IDLE;
						set_done = 1'b1;
					end
				end
			end
			PH_BUSY_SETTLE: begin
				// busy pin lags the last write; do not sample it too early
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.phase = PH_WAIT_READY;
				end
			end
			PH_WAIT_READY: begin
				// no timeout here: a stuck device keeps the block busy
				if (ready_sync) begin
					nxt_st.phase = PH_IDLE;
					set_done = 1'b1;
				end
			end
			PH_RD_ACCESS: begin
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.rdata = dq_sync;
					nxt_st.pins.ce_n = 1'b1;
					nxt_st.pins.oe_n = 1'b1;
					nxt_st.phase = PH_IDLE;
					set_done = 1'b1;
				end
			end
			PH_RST_PULSE: begin
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.pins.reset_n = 1'b1;
					nxt_st.cnt = RH_CYC;
					nxt_st.phase = PH_RST_RECOVER;
				end
			end
			PH_RST_RECOVER: begin
				nxt_st.cnt = st_ff.cnt - 8'd1;
				if (st_ff.cnt <= 8'd1) begin
					nxt_st.phase = PH_IDLE;
					set_done = 1'b1;
				end
			end
		endcase

		if (begin_write) begin
			nxt_st.step = bw;
			nxt_st.phase = PH_WR_SETUP;
			nxt_st.cnt = AS_CYC;
			nxt_st.pins.addr = step_addr(bw.akind, st_ff.addr_reg);
			nxt_st.pins.dq_out = bw.use_wdata ? st_ff.wdata_reg : {8'h00, bw.code};
			nxt_st.pins.dq_oe = 1'b1;
			nxt_st.pins.ce_n = 1'b0;
			nxt_st.pins.oe_n = 1'b1;
			nxt_st.pins.we_n = 1'b1;
		end

		// high voltage on reset only around a protect or unprotect write, or when asked
		nxt_st.pins.reset_vid = (((nxt_st.phase == PH_WR_SETUP) || (nxt_st.phase == PH_WR_LOW) ||
			(nxt_st.phase == PH_WR_HOLD)) &&
			((nxt_st.step.akind == AK_PROT) || (nxt_st.step.akind == AK_UNPROT))) ||
			nxt_st.pin_ctrl[PC_RESET_VID];
		nxt_st.pins.wp_accel = nxt_st.pin_ctrl[PC_WP_HIGH];
		nxt_st.pins.wp_accel_vid = nxt_st.pin_ctrl[PC_WP_VID];

		// sticky flags: a new event beats a clear in the same cycle
		nxt_st.done = (st_ff.done && !clr[0]) || set_done;
		nxt_st.err = (st_ff.err && !clr[1]) || set_err;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_ff <= ST_RESET;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign o_apb.prdata = st_ff.prdata;
	assign o_apb.pslverr = st_ff.pslverr;
	assign o_apb.pready = i_apb.psel && i_apb.penable;
	assign o_flash = st_ff.pins;
endmodule // nor_flash_host

// ===== verif/nor_flash_host_assertions.sv
`timescale 1ns/1ps
module nor_flash_host_assertions (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire nor_host_pkg::apb_req_type i_apb,
	input wire nor_host_pkg::apb_rsp_type o_apb,
	input wire nor_host_pkg::flash_pins_type o_flash,
	input wire logic [15:0] i_dq_in,
	input wire logic i_ready_busy_n
);
	import nor_host_pkg::*;
	// ************************************************************
	// port relations
	// ************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_zero_wait: assert property (i_apb.psel && i_apb.penable |-> o_apb.pready)
		else $error("access cycle without ready");
	a_unmapped_err: assert property (i_apb.psel && !i_apb.penable && i_apb.paddr > 8'h14
		|=> o_apb.pslverr)
		else $error("unmapped offset not refused");
	a_addr_setup: assert property ($fell(o_flash.we_n)
		|-> !$past(o_flash.ce_n) && $stable(o_flash.addr) && o_flash.oe_n)
		else $error("address not set up before write strobe");
	a_we_pulse: assert property ($fell(o_flash.we_n) |=> !o_flash.we_n ##1 o_flash.we_n)
		else $error("write strobe width wrong");
	a_data_held: assert property (!o_flash.we_n
		|-> o_flash.dq_oe && !o_flash.ce_n && $stable(o_flash.dq_out))
		else $error("data moved while strobe low");
	a_hold_after: assert property ($rose(o_flash.we_n)
		|-> !o_flash.ce_n && o_flash.dq_oe && $stable(o_flash.dq_out))
		else $error("data not held past strobe rise");
	a_read_strobes: assert property ($fell(o_flash.oe_n)
		|-> (!o_flash.ce_n && !o_flash.dq_oe && o_flash.we_n)[*7])
		else $error("read access cut short or contended");
	a_reset_pulse: assert property ($fell(o_flash.reset_n)
		|-> ##24 !o_flash.reset_n ##1 o_flash.reset_n)
		else $error("hardware reset pulse length wrong");
	a_prot_vid: assert property ($fell(o_flash.we_n) && o_flash.reset_vid
		|-> o_flash.addr[11:0] == PROT_LOW || o_flash.addr[11:0] == UNPROT_LOW)
		else $error("protect write with wrong low address");
	a_idle_reset: assert property ($fell(i_reset)
		|-> o_flash.ce_n && o_flash.we_n && o_flash.reset_n && !o_flash.dq_oe)
		else $error("pins not idle after reset");
endmodule // nor_flash_host_assertions

bind nor_flash_host nor_flash_host_assertions chk (.i_clk(i_clk), .i_reset(i_reset),
	.i_apb(i_apb), .o_apb(o_apb), .o_flash(o_flash), .i_dq_in(i_dq_in),
	.i_ready_busy_n(i_ready_busy_n));

// ===== verif/flash_model.sv
`timescale 1ns/1ps
module flash_model #(
	parameter logic [15:0] ID0 = 16'h0011,
	parameter logic [15:0] ID1 = 16'h0022,
	parameter logic [15:0] ID2 = 16'h0033,
	parameter logic [15:0] ID3 = 16'h0044,
	parameter logic [15:0] LOCK = 16'h0080,
	parameter int BUSY_NS = 2000
) (
	input wire nor_host_pkg::flash_pins_type i_pins,
	output logic [15:0] o_dq,
	output logic o_ready_busy_n
);
	import nor_host_pkg::*;
	// ************************************************************
	// array, modes and sequence decoder
	// ************************************************************
	// id values above are arbitrary
	logic [15:0] mem [logic [22:0]];
	logic [22:0] kq[$];
	logic prot [270];
	logic [22:0] la;
	logic [15:0] pd, lastv;
	logic byp, idm, esusp, psusp, tog;
	int step, kind;
	time done_at;
	function automatic int blk(input logic [22:0] a);
		if (a[22:15] == 8'h00) return int'(a[14:12]);
		if (a[22:15] == 8'hFF) return 262 + int'(a[14:12]);
		return 7 + int'(a[22:15]);
	endfunction
	function automatic logic locked(input logic [22:0] a);
		if (i_pins.wp_accel_vid || i_pins.reset_vid) return 1'b0;
		return prot[blk(a)] || (!i_pins.wp_accel && (blk(a) == 0 || blk(a) == 269));
	endfunction
	task automatic go(input int k);
		kind = k;
		o_ready_busy_n = 1'b0;
		done_at = $time + BUSY_NS;
	endtask
	task automatic wcyc(input logic [22:0] a, input logic [15:0] d);
		logic [7:0] c;
		logic [11:0] lo;
		c = d[7:0];
		lo = a[11:0];
		if (i_pins.reset_vid) begin
			if (lo[1] && !lo[0]) prot[blk(a)] = !lo[6];
			step = 0;
		end else if (!o_ready_busy_n) begin
			if (c == 8'hB0 && kind != 3) begin
				psusp = (kind == 1);
				esusp = (kind == 2);
				o_ready_busy_n = 1'b1;
			end
		end else if (psusp) begin
			if (c == 8'h30) begin
				psusp = 1'b0;
				go(1);
			end
		end else if (c == 8'hF0) begin
			step = 0;
			idm = 1'b0;
		end else if (esusp && step == 0 && c == 8'h30) begin
			esusp = 1'b0;
			go(2);
		end else if (step == 10) begin
			if (!locked(a)) mem[a] = (mem.exists(a) ? mem[a] : 16'hFFFF) & d;
			pd = d;
			step = 0;
			go(1);
		end else if (step == 5 || step == 20) begin
			if (c == 8'h30) begin
				kq.delete();
				foreach (mem[k]) if (blk(k) == blk(a) && !locked(a)) kq.push_back(k);
				foreach (kq[i]) mem.delete(kq[i]);
				go(2);
			end else if (c == 8'h10 && (byp || lo == 12'h555)) begin
				mem.delete();
				go(3);
			end
			step = 0;
		end else if (step == 21) begin
			if (c == 8'h00) byp = 1'b0;
			step = 0;
		end else if (byp && step == 0) begin
			step = c == 8'hA0 ? 10 : c == 8'h80 ? 20 : c == 8'h90 ? 21 : 0;
		end else if (step == 2 && lo == 12'h555) begin
			step = c == 8'hA0 ? 10 : c == 8'h80 ? 3 : 0;
			if (c == 8'h90) idm = 1'b1;
			if (c == 8'h20) byp = 1'b1;
		end else if (c == 8'hAA && lo == 12'h555 && (step == 0 || step == 3)) begin
			step = step + 1;
		end else if (c == 8'h55 && lo == 12'h2AA && (step == 1 || step == 4)) begin
			step = step + 1;
		end else begin
			step = 0;
		end
	endtask
	function automatic logic [15:0] val(input logic [22:0] a);
		if (!o_ready_busy_n) return {8'h00, ~pd[7], tog, 6'h00};
		if (idm) begin
			case (a[7:0])
				8'h00: return ID0;
				8'h01: return ID1;
				8'h0E: return ID2;
				8'h0F: return ID3;
				8'h02: return {15'h0000, prot[blk(a)]};
				8'h03: return LOCK;
				default: return 16'h0000;
			endcase
		end
		return mem.exists(a) ? mem[a] : 16'hFFFF;
	endfunction
	// ************************************************************
	// pins
	// ************************************************************
	initial begin
		{byp, idm, esusp, psusp, tog} = 5'h00;
		{step, kind, pd, lastv} = '0;
		o_ready_busy_n = 1'b1;
		foreach (prot[i]) prot[i] = 1'b0;
	end
	always @(negedge i_pins.we_n or negedge i_pins.ce_n) begin
		if (!i_pins.ce_n && !i_pins.we_n) la = i_pins.addr;
	end
	always @(posedge i_pins.we_n or posedge i_pins.ce_n) begin
		if (!i_pins.ce_n || !i_pins.we_n) wcyc(la, i_pins.dq_out);
	end
	always @(negedge i_pins.oe_n) tog = ~tog;
	always @(posedge i_pins.oe_n) lastv = o_dq;
	// released bus shows the inverse, never a stale value
	always @* o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? val(i_pins.addr) : ~lastv;
	always #10 if (!o_ready_busy_n && !psusp && $time >= done_at) o_ready_busy_n = 1'b1;
	always @(negedge i_pins.reset_n) begin
		{byp, idm, esusp, psusp} = 4'h0;
		step = 0;
		o_ready_busy_n = 1'b1;
	end
endmodule // flash_model

// ===== verif/testbench.sv
`timescale 1ns/1ps
`define CHK(n, x, g) begin cmp_count++; if ((g) !== (x)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, x, g); end end
module testbench;
	import nor_host_pkg::*;
	// ************************************************************
	// harness
	// ************************************************************
	localparam logic [22:0] PA = 23'h012345;
	localparam logic [22:0] PB = {PA[22:12], 12'h002};
	localparam logic [7:0] ID_OFF [4] = '{8'h00, 8'h01, 8'h0E, 8'h0F};
	// arbitrary id values
	localparam logic [15:0] ID_VAL [4] = '{16'h0011, 16'h0022, 16'h0033, 16'h0044};
	logic i_clk, i_reset, rbn, e;
	logic [15:0] dq;
	logic [31:0] q;
	apb_req_type req;
	apb_rsp_type rsp;
	flash_pins_type pins;
	int bad_count, cmp_count;
	nor_flash_host dut (.i_clk(i_clk), .i_reset(i_reset), .i_apb(req), .o_apb(rsp),
		.o_flash(pins), .i_dq_in(dq), .i_ready_busy_n(rbn));
	flash_model #(.ID0(ID_VAL[0]), .ID1(ID_VAL[1]), .ID2(ID_VAL[2]), .ID3(ID_VAL[3]),
		.LOCK(16'h0080)) fm (.i_pins(pins), .o_dq(dq), .o_ready_busy_n(rbn));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic close_out;
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge i_clk);
		req.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1) begin
			bad_count++;
			close_out();
		end
		q = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
		apb(1'b0, a, 32'h0);
		`CHK(s, x, q)
	endtask
	task automatic op(input op_type o, input logic [22:0] a, input logic [15:0] d);
		int n;
		apb(1'b1, OFF_ADDR, {9'h000, a});
		apb(1'b1, OFF_WDATA, {16'h0000, d});
		apb(1'b1, OFF_CMD, {28'h0, o});
		if (o == OP_PROGRAM) begin
			apb(1'b1, OFF_CMD, 32'h0);
			`CHK("cmd while busy", 1'b1, e)
			apb(1'b0, OFF_STATUS, 32'h0);
			`CHK("busy status", 3'b101, q[2:0])
		end
		n = 0;
		do begin
			apb(1'b0, OFF_STATUS, 32'h0);
			n++;
		end while (q[1] !== 1'b1 && n < 1000);
		if (q[1] !== 1'b1) begin
			bad_count++;
			close_out();
		end
		apb(1'b1, OFF_STATUS, 32'h6);
	endtask
	task automatic rw(input logic [22:0] a, input logic [15:0] x, input string s);
		op(OP_READ, a, 16'h0000);
		rd(OFF_RDATA, {16'h0000, x}, s);
	endtask
	// ************************************************************
	// sequence
	// ************************************************************
	initial begin
		i_reset = 1'b1;
		req = '0;
		bad_count = 0;
		cmp_count = 0;
		repeat (16) @(posedge i_clk);
		i_reset <= 1'b0;
		// status already shows the synced ready level by its turn
		foreach (ID_OFF[i]) rd(8'(4 * i), (i == 3) ? 32'h8 : 32'h0, "reg reset");
		rd(OFF_STATUS, 32'h8, "status reset");
		rd(OFF_PINCTRL, 32'h0, "pinctrl reset");
		rd(8'h18, 32'h0, "unmapped");
		`CHK("unmapped err", 1'b1, e)
		apb(1'b1, OFF_PINCTRL, 32'h1);
		op(OP_PROGRAM, PA, 16'h1234);
		rw(PA, 16'h1234, "program");
		op(OP_PROGRAM, PA, 16'h00FF);
		rw(PA, 16'h0034, "reprogram");
		rw(PA + 23'h1, 16'hFFFF, "neighbour");
		op(OP_SUSPEND, PA, 16'h0);
		op(OP_RESUME, PA, 16'h0);
		rw(PA, 16'h0034, "idle suspend");
		op(OP_BLOCK_ERASE, PA, 16'h0);
		rw(PA, 16'hFFFF, "block erase");
		op(OP_PROGRAM, 23'h400000, 16'hA5A5);
		op(OP_CHIP_ERASE, 23'h0, 16'h0);
		rw(23'h400000, 16'hFFFF, "chip erase");
		op(OP_PROTECT, PA, 16'h0);
		op(OP_AUTOSELECT, 23'h300000, 16'h0);
		foreach (ID_OFF[i]) rw({15'h3000, ID_OFF[i]}, ID_VAL[i], "ident");
		rw(PB, 16'h0001, "protect bit");
		rw(23'h300003, 16'h0080, "lock word");
		op(OP_RESET, 23'h0, 16'h0);
		rw(PA, 16'hFFFF, "left ident");
		op(OP_PROGRAM, PA, 16'h5555);
		rw(PA, 16'hFFFF, "protected");
		apb(1'b1, OFF_PINCTRL, 32'h3);
		op(OP_PROGRAM, PA, 16'h5555);
		rw(PA, 16'h5555, "accel vid");
		apb(1'b1, OFF_PINCTRL, 32'h1);
		op(OP_UNPROTECT, PA, 16'h0);
		op(OP_BLOCK_ERASE, PA, 16'h0);
		rw(PA, 16'hFFFF, "unprotected");
		apb(1'b1, OFF_PINCTRL, 32'h0);
		op(OP_PROGRAM, 23'h10, 16'h0);
		rw(23'h10, 16'hFFFF, "boot locked");
		apb(1'b1, OFF_PINCTRL, 32'h1);
		op(OP_PROGRAM, 23'h10, 16'h0);
		rw(23'h10, 16'h0000, "boot free");
		op(OP_BYPASS_ENTER, 23'h0, 16'h0);
		op(OP_BYPASS_PROGRAM, PA, 16'h0F0F);
		rw(PA, 16'h0F0F, "bypass program");
		op(OP_BYPASS_BLOCK_ERASE, PA, 16'h0);
		rw(PA, 16'hFFFF, "bypass block");
		op(OP_BYPASS_PROGRAM, PA, 16'h0F0F);
		op(OP_BYPASS_CHIP_ERASE, 23'h0, 16'h0);
		rw(PA, 16'hFFFF, "bypass chip");
		op(OP_BYPASS_EXIT, 23'h0, 16'h0);
		op(OP_BYPASS_PROGRAM, PA, 16'h0F0F);
		rw(PA, 16'hFFFF, "no bypass");
		op(OP_HW_RESET, 23'h0, 16'h0);
		rd(OFF_STATUS, 32'h8, "ready");
		close_out();
	end
	initial begin
		repeat (90000) @(posedge i_clk);
		bad_count++;
		close_out();
	end
endmodule // testbench
